// ==== rtl/iaclm_consts.vh ====
// constants for the ipv4 access control entry matcher
`ifndef IACLM_CONSTS_VH
`define IACLM_CONSTS_VH
// ****************************************************************
// register word offsets
// ****************************************************************
`define IACLM_REG_CTRL      4'h0
`define IACLM_REG_PROTO     4'h1
`define IACLM_REG_SRC_ADDR  4'h2
`define IACLM_REG_SRC_MASK  4'h3
`define IACLM_REG_DST_ADDR  4'h4
`define IACLM_REG_DST_MASK  4'h5
`define IACLM_REG_STATUS    4'h6
`define IACLM_REG_HITCNT    4'h7
// ****************************************************************
// control register fields (low bit positions; ipv4 one bit, protocol three bits, others two bits each)
// ****************************************************************
`define IACLM_CTRL_IPV4     0
`define IACLM_CTRL_PROTO    1
`define IACLM_CTRL_TTL      4
`define IACLM_CTRL_FRAG     6
`define IACLM_CTRL_OPT      8
`define IACLM_CTRL_SRC      10
`define IACLM_CTRL_DST      12
`define IACLM_CTRL_RESET    32'h0000_0000
// ****************************************************************
// criterion encodings
// ****************************************************************
`define IACLM_PROTO_ANY     3'h0
`define IACLM_PROTO_SPEC    3'h1
`define IACLM_PROTO_ICMP    3'h2
`define IACLM_PROTO_UDP     3'h3
`define IACLM_PROTO_TCP     3'h4
`define IACLM_TRI_ANY       2'h0
`define IACLM_TRI_NO        2'h1
`define IACLM_TRI_YES       2'h2
`define IACLM_ADDR_ANY      2'h0
`define IACLM_ADDR_HOST     2'h1
`define IACLM_ADDR_NET      2'h2
`define IACLM_NUM_ICMP      8'h01
`define IACLM_NUM_TCP       8'h06
`define IACLM_NUM_UDP       8'h11
`endif

// ==== rtl/iaclm_addr_match.v ====
// address criterion comparator: any, host or masked network
`timescale 1ns/1ps
`default_nettype none
`include "iaclm_consts.vh"
module iaclm_addr_match #(
  parameter WIDTH = 32
) (
  input  wire [1:0]       mode,
  input  wire [WIDTH-1:0] frameAddr,
  input  wire [WIDTH-1:0] cfgAddr,
  input  wire [WIDTH-1:0] cfgMask,
  output reg              ok
);
  // compare per mode
  always @* begin
    case (mode)
      `IACLM_ADDR_ANY:  ok = 1'b1;
      `IACLM_ADDR_HOST: ok = (frameAddr == cfgAddr);
      `IACLM_ADDR_NET:  ok = ((frameAddr & cfgMask) == (cfgAddr & cfgMask));
      default:          ok = 1'b0;
    endcase
  end
endmodule // iaclm_addr_match
`default_nettype wire

// ==== rtl/iaclm_matcher.v ====
// ipv4 access control entry matcher with avalon-mm register slave
// Behaviour
// - ipv4 criteria apply only when entry frame type selects ipv4
// - protocol any ignores the protocol field
// - protocol specific needs field equal to configured 8-bit value
// - icmp selection needs protocol icmp, plus icmp criteria pass
// - udp selection needs protocol udp, plus udp port criteria pass
// - tcp selection needs protocol tcp, plus tcp port and flag criteria
// - lifetime zero rejects frames with ttl above zero
// - lifetime non-zero needs ttl above zero; any ignores ttl
// - fragment no rejects frames with more-fragments or nonzero offset
// - fragment yes needs fragmented frame; any ignores fragmentation
// - options no rejects frames carrying header options
// - options yes needs options present; any ignores options
// - source any ignores source address
// - source host needs exact 32-bit source address equality
// - source network compares only bits where source mask is one
// - destination any ignores destination address
// - destination host needs exact 32-bit destination equality
// - destination network compares only bits where destination mask is one
`timescale 1ns/1ps
`default_nettype none
`include "iaclm_consts.vh"
module iaclm_matcher #(
  parameter ADDR_W = 32
) (
  input  wire              clock,
  input  wire              reset_n,
  // avalon-mm slave, word addressed
  input  wire [3:0]        address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  output reg  [31:0]       readdata,
  output reg               waitrequest,
  output reg  [1:0]        response,
  // decoded header from the parser
  input  wire              frameValid,
  input  wire              frameIsIpv4,
  input  wire [7:0]        frameProto,
  input  wire [7:0]        frameTtl,
  input  wire              frameMoreFrag,
  input  wire [12:0]       frameFragOffset,
  input  wire              frameHasOptions,
  input  wire [ADDR_W-1:0] frameSrcAddr,
  input  wire [ADDR_W-1:0] frameDstAddr,
  input  wire              frameL4Ok,
  // verdict
  output reg               resultValid_q,
  output reg               entryHit_q
);
  // ****************************************************************
  // configuration and status registers
  // ****************************************************************
  reg  [31:0]       ctrl_q;
  reg  [7:0]        protoValue_q;
  reg  [ADDR_W-1:0] srcAddr_q;
  reg  [ADDR_W-1:0] srcMask_q;
  reg  [ADDR_W-1:0] dstAddr_q;
  reg  [ADDR_W-1:0] dstMask_q;
  reg  [31:0]       hitCount_q;
  reg               busy_q;

  wire       selIpv4  = ctrl_q[`IACLM_CTRL_IPV4];
  wire [2:0] protoSel = ctrl_q[`IACLM_CTRL_PROTO+2:`IACLM_CTRL_PROTO];
  wire [1:0] ttlSel   = ctrl_q[`IACLM_CTRL_TTL+1:`IACLM_CTRL_TTL];
  wire [1:0] fragSel  = ctrl_q[`IACLM_CTRL_FRAG+1:`IACLM_CTRL_FRAG];
  wire [1:0] optSel   = ctrl_q[`IACLM_CTRL_OPT+1:`IACLM_CTRL_OPT];
  wire [1:0] srcSel   = ctrl_q[`IACLM_CTRL_SRC+1:`IACLM_CTRL_SRC];
  wire [1:0] dstSel   = ctrl_q[`IACLM_CTRL_DST+1:`IACLM_CTRL_DST];

  // ****************************************************************
  // criterion evaluation
  // ****************************************************************
  reg protoOk;
  reg ttlOk;
  reg fragOk;
  reg optOk;
  wire srcOk;
  wire dstOk;
  wire isFragment = frameMoreFrag | (frameFragOffset != 13'h0000);
  wire ttlAboveZero = (frameTtl != 8'h00);

  // protocol criterion
  always @* begin
    case (protoSel)
      `IACLM_PROTO_ANY:  protoOk = 1'b1;
      `IACLM_PROTO_SPEC: protoOk = (frameProto == protoValue_q);
      `IACLM_PROTO_ICMP: protoOk = (frameProto == `IACLM_NUM_ICMP) & frameL4Ok;
      `IACLM_PROTO_UDP:  protoOk = (frameProto == `IACLM_NUM_UDP) & frameL4Ok;
      `IACLM_PROTO_TCP:  protoOk = (frameProto == `IACLM_NUM_TCP) & frameL4Ok;
      default:           protoOk = 1'b0;
    endcase
  end

  // lifetime criterion
  always @* begin
    case (ttlSel)
      `IACLM_TRI_ANY: ttlOk = 1'b1;
      `IACLM_TRI_NO:  ttlOk = ~ttlAboveZero;
      `IACLM_TRI_YES: ttlOk = ttlAboveZero;
      default:        ttlOk = 1'b0;
    endcase
  end

  // fragment criterion
  always @* begin
    case (fragSel)
      `IACLM_TRI_ANY: fragOk = 1'b1;
      `IACLM_TRI_NO:  fragOk = ~isFragment;
      `IACLM_TRI_YES: fragOk = isFragment;
      default:        fragOk = 1'b0;
    endcase
  end

  // options criterion
  always @* begin
    case (optSel)
      `IACLM_TRI_ANY: optOk = 1'b1;
      `IACLM_TRI_NO:  optOk = ~frameHasOptions;
      `IACLM_TRI_YES: optOk = frameHasOptions;
      default:        optOk = 1'b0;
    endcase
  end

  iaclm_addr_match #(
    .WIDTH     (ADDR_W)
  ) uSrcMatch (
    .mode      (srcSel),
    .frameAddr (frameSrcAddr),
    .cfgAddr   (srcAddr_q),
    .cfgMask   (srcMask_q),
    .ok        (srcOk)
  );

  iaclm_addr_match #(
    .WIDTH     (ADDR_W)
  ) uDstMatch (
    .mode      (dstSel),
    .frameAddr (frameDstAddr),
    .cfgAddr   (dstAddr_q),
    .cfgMask   (dstMask_q),
    .ok        (dstOk)
  );

  wire ipv4CritOk = protoOk & ttlOk & fragOk & optOk & srcOk & dstOk;
  wire entryHit_d = selIpv4 ? (frameIsIpv4 & ipv4CritOk) : 1'b0;

  // ****************************************************************
  // verdict registers
  // ****************************************************************
  // one verdict per frameValid pulse, one cycle later
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resultValid_q <= 1'b0;
      entryHit_q    <= 1'b0;
      hitCount_q    <= 32'h0000_0000;
    end else begin
      resultValid_q <= frameValid;
      entryHit_q    <= frameValid & entryHit_d;
      if (frameValid && entryHit_d) begin
        hitCount_q <= hitCount_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // avalon-mm slave
  // ****************************************************************
  wire request = (read | write) & ~busy_q;
  reg  [31:0] readMux;
  reg         addrValid;

  // read multiplexer and decode
  always @* begin
    addrValid = 1'b1;
    case (address)
      `IACLM_REG_CTRL:     readMux = ctrl_q;
      `IACLM_REG_PROTO:    readMux = {24'h000000, protoValue_q};
      `IACLM_REG_SRC_ADDR: readMux = srcAddr_q;
      `IACLM_REG_SRC_MASK: readMux = srcMask_q;
      `IACLM_REG_DST_ADDR: readMux = dstAddr_q;
      `IACLM_REG_DST_MASK: readMux = dstMask_q;
      `IACLM_REG_STATUS:   readMux = {30'h00000000, entryHit_q, resultValid_q};
      `IACLM_REG_HITCNT:   readMux = hitCount_q;
      default: begin
        readMux   = 32'h0000_0000;
        addrValid = 1'b0;
      end
    endcase
  end

  // one wait cycle, answer on second edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_q       <= 1'b0;
      waitrequest  <= 1'b1;
      readdata     <= 32'h0000_0000;
      response     <= 2'h0;
      ctrl_q       <= `IACLM_CTRL_RESET;
      protoValue_q <= 8'h00;
      srcAddr_q    <= {ADDR_W{1'b0}};
      srcMask_q    <= {ADDR_W{1'b0}};
      dstAddr_q    <= {ADDR_W{1'b0}};
      dstMask_q    <= {ADDR_W{1'b0}};
    end else begin
      busy_q      <= request;
      waitrequest <= ~request;
      if (request) begin
        readdata <= read ? readMux : 32'h0000_0000;
        response <= addrValid ? 2'h0 : 2'h3;
      end
      if (request && write) begin
        case (address)
          `IACLM_REG_CTRL:     ctrl_q       <= {18'h00000, writedata[13:0]};
          `IACLM_REG_PROTO:    protoValue_q <= writedata[7:0];
          `IACLM_REG_SRC_ADDR: srcAddr_q    <= writedata[ADDR_W-1:0];
          `IACLM_REG_SRC_MASK: srcMask_q    <= writedata[ADDR_W-1:0];
          `IACLM_REG_DST_ADDR: dstAddr_q    <= writedata[ADDR_W-1:0];
          `IACLM_REG_DST_MASK: dstMask_q    <= writedata[ADDR_W-1:0];
          default: begin
          end
        endcase
      end
    end
  end
endmodule // iaclm_matcher
`default_nettype wire

// ==== tb/iaclm_asserts.sv ====
// checker for the ipv4 entry matcher
`timescale 1ns/1ps
`default_nettype none
`include "iaclm_consts.vh"
module iaclm_asserts (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [3:0]  address,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  input wire logic        frameValid,
  input wire logic        frameIsIpv4,
  input wire logic [7:0]  frameProto,
  input wire logic [7:0]  frameTtl,
  input wire logic        frameMoreFrag,
  input wire logic [12:0] frameFragOffset,
  input wire logic        frameHasOptions,
  input wire logic [31:0] frameSrcAddr,
  input wire logic [31:0] frameDstAddr,
  input wire logic        frameL4Ok,
  input wire logic        resultValid_q,
  input wire logic        entryHit_q
);
  logic [31:0] cfg [0:6];
  logic [2:0]  ps;
  logic        pOk, sOk, dOk, hitX;
  function automatic logic tri3(input logic [1:0] m, input logic v);
    return m == 2'h0 || (m == 2'h1 && !v) || (m == 2'h2 && v);
  endfunction
  function automatic logic am(input logic [1:0] m, input logic [31:0] f, a, k);
    return m == 2'h0 || (m == 2'h1 && f == a) || (m == 2'h2 && ((f ^ a) & k) == 32'h0);
  endfunction
  // shadow of the configuration words
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) cfg <= '{default: 32'h0};
    else if (write && !waitrequest && address < 4'h6) cfg[address] <= writedata;
  end
  // expected verdict for the frame now offered
  always_comb begin
    ps = cfg[0][3:1];
    pOk = ps == 3'h0 || (ps == 3'h1 && frameProto == cfg[1][7:0]) || (frameL4Ok &&
      ((ps == 3'h2 && frameProto == `IACLM_NUM_ICMP) || (ps == 3'h3 &&
      frameProto == `IACLM_NUM_UDP) || (ps == 3'h4 && frameProto == `IACLM_NUM_TCP)));
    sOk = am(cfg[0][11:10], frameSrcAddr, cfg[2], cfg[3]);
    dOk = am(cfg[0][13:12], frameDstAddr, cfg[4], cfg[5]);
    hitX = cfg[0][0] && frameIsIpv4 && pOk && sOk && dOk && tri3(cfg[0][5:4], frameTtl != 8'h0)
      && tri3(cfg[0][7:6], frameMoreFrag || frameFragOffset != 13'h0)
      && tri3(cfg[0][9:8], frameHasOptions);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence miss_s;
    resultValid_q && !entryHit_q;
  endsequence
  verdict_latency_a: assert property (frameValid |=> resultValid_q)
    else $error("verdict missing");
  no_spurious_a: assert property (!frameValid |=> !resultValid_q && !entryHit_q)
    else $error("verdict without frame");
  verdict_exact_a: assert property (frameValid |=> entryHit_q == $past(hitX))
    else $error("wrong verdict");
  type_gate_a: assert property (frameValid && !cfg[0][0] |=> miss_s)
    else $error("hit on non ipv4 entry");
  proto_sel_a: assert property (frameValid && !pOk |=> miss_s)
    else $error("protocol mismatch hit");
  ttl_zero_a: assert property (frameValid && cfg[0][5:4] == 2'h1 && frameTtl != 8'h0 |=> miss_s)
    else $error("ttl zero violated");
  frag_no_a: assert property (frameValid && cfg[0][7:6] == 2'h1 &&
    (frameMoreFrag || frameFragOffset != 13'h0) |=> miss_s)
    else $error("fragment hit");
  opt_no_a: assert property (frameValid && cfg[0][9:8] == 2'h1 && frameHasOptions |=> miss_s)
    else $error("options hit");
  src_match_a: assert property (frameValid && !sOk |=> miss_s)
    else $error("source mismatch hit");
  dst_match_a: assert property (frameValid && !dOk |=> miss_s)
    else $error("destination mismatch hit");
endmodule // iaclm_asserts
bind iaclm_matcher iaclm_asserts chk (.clock, .reset_n, .address, .write, .writedata,
  .waitrequest, .frameValid, .frameIsIpv4, .frameProto, .frameTtl, .frameMoreFrag, .frameFragOffset,
  .frameHasOptions, .frameSrcAddr, .frameDstAddr, .frameL4Ok, .resultValid_q, .entryHit_q);
`default_nettype wire

// ==== tb/iaclm_parser_model.sv ====
// parser model feeding decoded headers
`timescale 1ns/1ps
`default_nettype none
module iaclm_parser_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        go,
  input  wire logic [96:0] hdrIn,
  output var  logic        frameValid,
  output var  logic [96:0] hdr_q
);
  // one valid cycle per request; fields churn while idle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frameValid <= 1'b0;
      hdr_q      <= 97'h0;
    end else begin
      frameValid <= go;
      hdr_q      <= go ? hdrIn : ~hdr_q;
    end
  end
endmodule // iaclm_parser_model
`default_nettype wire

// ==== tb/tb_ipv4_acl_entry_matcher.sv ====
// testbench for the ipv4 entry matcher
`timescale 1ns/1ps
`default_nettype none
`include "iaclm_consts.vh"
module tb_ipv4_acl_entry_matcher;
  logic        clock = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, go = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rdQ;
  logic [1:0]  response, rsQ;
  logic        waitrequest, frameValid, resultValid_q, entryHit_q;
  logic [96:0] hdrIn = 97'h0, hdr, h;
  int          n_fail = 0, num_checks = 0;
  localparam logic [96:0] B = {1'b1, 8'h06, 8'h40, 1'b0, 13'h0, 1'b0, 32'hC0A8_0105,
    32'h0A00_0001, 1'b1};
  localparam logic [7:0] PN [3] = '{`IACLM_NUM_ICMP, `IACLM_NUM_UDP, `IACLM_NUM_TCP};
  always #50 clock = ~clock;
  iaclm_parser_model PM (.clock, .reset_n, .go, .hdrIn, .frameValid, .hdr_q(hdr));
  iaclm_matcher DUT (.clock, .reset_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .response, .frameValid, .frameIsIpv4(hdr[96]), .frameProto(hdr[95:88]),
    .frameTtl(hdr[87:80]), .frameMoreFrag(hdr[79]), .frameFragOffset(hdr[78:66]),
    .frameHasOptions(hdr[65]), .frameSrcAddr(hdr[64:33]), .frameDstAddr(hdr[32:1]),
    .frameL4Ok(hdr[0]), .resultValid_q, .entryHit_q);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rdQ = readdata;
    rsQ = response;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // one frame through the parser model, verdict judged
  task automatic fr(input logic [96:0] x, input logic e);
    @(posedge clock);
    go <= 1'b1;
    hdrIn <= x;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1 chk(32'({resultValid_q, entryHit_q}), 32'({1'b1, e}));
  endtask
  task automatic t_regs;
    bus(1'b0, 4'h0, 32'h0);
    chk(rdQ, 32'h0);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF);
    bus(1'b0, 4'h0, 32'h0);
    chk(rdQ, 32'h0000_3FFF);
    chk(32'(rsQ), 32'h0);
    bus(1'b1, 4'h1, 32'hFFFF_FFA5);
    bus(1'b0, 4'h1, 32'h0);
    chk(rdQ, 32'h0000_00A5);
    bus(1'b0, 4'h9, 32'h0);
    chk(32'(rsQ), 32'h3);
    $display("test regs done");
  endtask
  task automatic t_gate;
    logic [31:0] c0;
    bus(1'b1, 4'h0, 32'h0);
    fr(B, 1'b0);
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b0, 4'h7, 32'h0);
    c0 = rdQ;
    fr(B, 1'b1);
    bus(1'b0, 4'h7, 32'h0);
    chk(rdQ, c0 + 32'h1);
    h = B;
    h[96] = 1'b0;
    fr(h, 1'b0);
    bus(1'b0, 4'h7, 32'h0);
    chk(rdQ, c0 + 32'h1);
    $display("test gate done");
  endtask
  task automatic t_proto;
    bus(1'b1, 4'h1, 32'hFF);
    bus(1'b1, 4'h0, 32'h3);
    h = B;
    h[95:88] = 8'hFF;
    fr(h, 1'b1);
    h[95:88] = 8'hFE;
    fr(h, 1'b0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 4'h0, 32'(5 + 2 * i));
      h = B;
      h[95:88] = PN[i];
      fr(h, 1'b1);
      h[0] = 1'b0;
      fr(h, 1'b0);
      h[0] = 1'b1;
      h[95:88] = PN[(i + 1) % 3];
      fr(h, 1'b0);
    end
    $display("test proto done");
  endtask
  task automatic t_tri;
    for (int k = 0; k < 3; k++)
      for (int m = 0; m < 3; m++) begin
        bus(1'b1, 4'h0, 32'h1 | (32'(m) << (4 + 2 * k)));
        for (int v = 0; v < 2; v++) begin
          h = B;
          if (k == 0) h[87:80] = v ? 8'h01 : 8'h00;
          if (k == 1) h[78:66] = v ? 13'h1FFF : 13'h0;
          if (k == 2) h[65] = 1'(v);
          fr(h, m == 0 || (m == 1) == (v == 0));
        end
      end
    bus(1'b1, 4'h0, 32'h41);
    h = B;
    h[79] = 1'b1;
    fr(h, 1'b0);
    $display("test tri done");
  endtask
  task automatic t_addr;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 4'(2 + 2 * i), 32'hC0A8_0100);
      bus(1'b1, 4'(3 + 2 * i), 32'hFFFF_FF00);
      bus(1'b1, 4'h0, 32'h1 | (32'h1 << (10 + 2 * i)));
      h = B;
      h[64 - 32 * i -: 32] = 32'hC0A8_0100;
      fr(h, 1'b1);
      h[64 - 32 * i -: 32] = 32'hC0A8_0101;
      fr(h, 1'b0);
      bus(1'b1, 4'h0, 32'h1 | (32'h2 << (10 + 2 * i)));
      fr(h, 1'b1);
      h[64 - 32 * i -: 32] = 32'hC0A8_0201;
      fr(h, 1'b0);
    end
    $display("test addr done");
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    t_regs;
    t_gate;
    t_proto;
    t_tri;
    t_addr;
    close_out;
  end
  // watchdog
  initial begin
    #500000;
    n_fail++;
    close_out;
  end
endmodule // tb_ipv4_acl_entry_matcher
`default_nettype wire
